// ===== hdl/exec_pkg.sv
// shared constants and types for the register and memory-reference executor
package exec_pkg;
   localparam int STATE_TICKS = 8;
   localparam logic [2:0] TICK_ADDR = 3'h1;
   localparam logic [2:0] TICK_STROBE_FIRST = 3'h2;
   localparam logic [2:0] TICK_SAMPLE = 3'h5;
   localparam logic [2:0] TICK_WRITEBACK = 3'h6;
   localparam logic [2:0] TICK_LAST = 3'h7;
   localparam logic [2:0] TICK_RESET = 3'h0;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [15:0] ADDR_RESET = 16'h0000;
   localparam logic [15:0] REG_READ_RESET = 16'h0000;
   localparam logic [3:0] DIGIT_RESET = 4'h0;
   // upper digits of the instruction groups handled here
   localparam logic [3:0] UP_LOAD_SEL = 4'h0;
   localparam logic [3:0] UP_INC = 4'h1;
   localparam logic [3:0] UP_DEC = 4'h2;
   localparam logic [3:0] UP_LOAD_ADV = 4'h4;
   localparam logic [3:0] UP_STORE_SEL = 4'h5;
   localparam logic [3:0] UP_SIX = 4'h6;
   localparam logic [3:0] UP_SEVEN = 4'h7;
   localparam logic [3:0] UP_GET_LO = 4'h8;
   localparam logic [3:0] UP_GET_HI = 4'h9;
   localparam logic [3:0] UP_PUT_LO = 4'hA;
   localparam logic [3:0] UP_PUT_HI = 4'hB;
   localparam logic [3:0] UP_LONG = 4'hC;
   localparam logic [3:0] UP_F = 4'hF;
   // lower digits of the fixed codes
   localparam logic [3:0] LO_ZERO = 4'h0;
   localparam logic [3:0] LO_LOAD_X_ADV = 4'h2;
   localparam logic [3:0] LO_STORE_X_DEC = 4'h3;
   localparam logic [3:0] LO_INLINE = 4'h8;
   localparam logic [3:0] LO_ILLEGAL = 4'h8;
   typedef enum logic [1:0] {
      fetch_state = 2'b00,
      execute_state = 2'b01,
      execute_second = 2'b10
   } machine_state_type;
endpackage

// ===== hdl/register_memory_op_exec.sv
// fetch and execute sequencer for register and memory-reference instructions
// Functional notes
// (RL1) fetch in fetch_state, execute once; long group gets two execute states
// (RL2) code 68 is illegal and must never be supplied by the program
// (RL3) 1N increments R(N), all ones wraps to zero
// (RL4) 2N decrements R(N), zero wraps to all ones
// (RL5) 60 increments the register picked by the operand-pointer selector
// (RL6) 8N copies low byte of R(N) into accumulator
// (RL7) AN writes accumulator into low byte of R(N) only
// (RL8) 9N copies high byte of R(N) into accumulator
// (RL9) BN writes accumulator into high byte of R(N) only
// (RL10) 0N with N nonzero loads accumulator from memory at R(N)
// (RL11) 4N loads accumulator from memory at R(N), then increments R(N)
// (RL12) F0 loads accumulator from memory at R(X), pointer untouched
// (RL13) 72 loads accumulator from memory at R(X), then increments R(X)
// (RL14) F8 loads inline byte via program counter and advances it again
// (RL15) 5N stores accumulator to memory at R(N)
// (RL16) 73 stores accumulator at R(X), then decrements R(X)
// (RL17) fetch reads byte at program counter into digits, then increments it
// (RL18) every machine state lasts eight clock ticks
// (RL19) memory access shows pointer as address with one strobe per state
module register_memory_op_exec
   import exec_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic [3:0] p_sel,
   input wire logic [3:0] x_sel,
   output logic [15:0] mem_addr,
   output logic mem_rd,
   output logic mem_wr,
   output logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata,
   output logic [7:0] acc,
   output logic [3:0] i_digit,
   output logic [3:0] n_digit,
   output logic [1:0] machine_state,
   output logic illegal_op
);
   machine_state_type state;
   machine_state_type next_state;
   logic [2:0] tick;
   logic [15:0] ptr;
   logic [15:0] rdata;
   logic illegal;

   initial begin
      if (STATE_TICKS != 8) begin
         $error("tick counter serves exactly eight ticks per state");
      end
   end

   wire in_fetch = (state == fetch_state);
   wire in_exec = (state == execute_state);
   wire up_f = (i_digit == UP_F);
   wire up_7 = (i_digit == UP_SEVEN);
   wire n_zero = (n_digit == LO_ZERO);
   wire op_60 = (i_digit == UP_SIX) && n_zero;
   wire op_72 = up_7 && (n_digit == LO_LOAD_X_ADV);
   wire op_73 = up_7 && (n_digit == LO_STORE_X_DEC);
   wire op_f0 = up_f && n_zero;
   wire op_f8 = up_f && (n_digit == LO_INLINE);
   wire op_0n = (i_digit == UP_LOAD_SEL) && !n_zero;
   wire op_4n = (i_digit == UP_LOAD_ADV);
   wire op_5n = (i_digit == UP_STORE_SEL);
   wire get_lo = in_exec && (i_digit == UP_GET_LO);
   wire get_hi = in_exec && (i_digit == UP_GET_HI);
   wire put_lo = in_exec && (i_digit == UP_PUT_LO);
   wire put_hi = in_exec && (i_digit == UP_PUT_HI);

   // pointer choice: program counter, operand selector or lower digit
   wire use_x = op_60 || op_72 || op_73 || op_f0;
   wire use_p = in_fetch || (in_exec && op_f8);
   wire [3:0] ptr_idx = use_p ? p_sel : (use_x ? x_sel : n_digit);

   // (RL10) (RL11) (RL12) (RL13) (RL14) memory loads
   wire do_read = in_fetch
      || (in_exec && (op_0n || op_4n || op_f0 || op_72 || op_f8));
   // (RL15) (RL16) memory stores
   wire do_write = in_exec && (op_5n || op_73);
   // (RL3) (RL5) (RL11) (RL13) (RL14) (RL17) pointer increment
   wire step_up = in_fetch || (in_exec && ((i_digit == UP_INC) || op_60
      || op_4n || op_72 || op_f8));
   // (RL4) (RL16) pointer decrement
   wire step_down = in_exec && ((i_digit == UP_DEC) || op_73);

   // (RL19) strobe spans ticks two to five, address settled at tick one
   wire strobe_win = (tick >= TICK_STROBE_FIRST) && (tick <= TICK_SAMPLE);
   assign mem_rd = strobe_win && do_read;
   assign mem_wr = strobe_win && do_write;

   wire at_addr = clk_en && (tick == TICK_ADDR);
   wire at_sample = clk_en && (tick == TICK_SAMPLE);
   wire at_wb = clk_en && (tick == TICK_WRITEBACK);
   wire at_last = (tick == TICK_LAST);

   // (RL3) (RL4) 16-bit wrap is natural in the sized sum
   wire [15:0] ptr_inc = ptr + 16'h0001;
   wire [15:0] ptr_dec = ptr - 16'h0001;
   // (RL7) (RL9) byte enables keep the other half untouched
   wire [1:0] wb_en = (step_up || step_down) ? 2'b11 :
      put_lo ? 2'b01 : (put_hi ? 2'b10 : 2'b00);
   wire [15:0] wb_data = step_up ? ptr_inc :
      step_down ? ptr_dec : {acc, acc};
   wire [1:0] rf_wr_en = at_wb ? wb_en : 2'b00;

   // (RL6) (RL8) register halves into the accumulator
   wire [7:0] next_acc = get_lo ? ptr[7:0] :
      get_hi ? ptr[15:8] : mem_rdata;
   wire acc_load = at_sample && (get_lo || get_hi || (in_exec && do_read));

   // (RL1) long group takes a second execute state
   always_comb begin
      unique case (state)
         fetch_state: next_state = execute_state;
         execute_state: next_state = (i_digit == UP_LONG) ?
            execute_second : fetch_state;
         execute_second: next_state = fetch_state;
         default: next_state = fetch_state;
      endcase
   end

   scratch_pad regs (
      .core_clk(core_clk),
      .rstn(rstn),
      .clk_en(clk_en),
      .raddr(ptr_idx),
      .rdata(rdata),
      .wr_en(rf_wr_en),
      .waddr(ptr_idx),
      .wdata(wb_data)
   );

   // (RL18) eight ticks per machine state
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tick <= TICK_RESET;
         state <= fetch_state;
      end else if (clk_en) begin
         tick <= tick + 3'h1;
         if (at_last) begin
            state <= next_state;
         end
      end
   end

   // (RL19) pointer latched once per state, drives the address lines
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ptr <= ADDR_RESET;
         mem_addr <= ADDR_RESET;
         mem_wdata <= ACC_RESET;
      end else if (at_addr) begin
         ptr <= rdata;
         mem_addr <= rdata;
         mem_wdata <= acc;
      end
   end

   // (RL17) fetched byte split into upper and lower digits
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         i_digit <= DIGIT_RESET;
         n_digit <= DIGIT_RESET;
      end else if (at_sample && in_fetch) begin
         i_digit <= mem_rdata[7:4];
         n_digit <= mem_rdata[3:0];
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         acc <= ACC_RESET;
      end else if (acc_load) begin
         acc <= next_acc;
      end
   end

   // (RL2) code 68 flagged, otherwise executed as a no-op
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         illegal <= 1'b0;
      end else if (clk_en) begin
         illegal <= at_wb && in_exec && (i_digit == UP_SIX)
            && (n_digit == LO_ILLEGAL);
      end
   end

   assign illegal_op = illegal;
   assign machine_state = state;
endmodule

// ===== hdl/scratch_pad.sv
// sixteen 16-bit scratch-pad registers, byte write enables, registered read
module scratch_pad
   import exec_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic [3:0] raddr,
   output logic [15:0] rdata,
   input wire logic [1:0] wr_en,
   input wire logic [3:0] waddr,
   input wire logic [15:0] wdata
);
   logic [15:0] regs [16];

   // array holds no reset: software must seed pointers before use
   always_ff @(posedge core_clk) begin
      if (clk_en && wr_en[0]) begin
         regs[waddr][7:0] <= wdata[7:0];
      end
      if (clk_en && wr_en[1]) begin
         regs[waddr][15:8] <= wdata[15:8];
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= REG_READ_RESET;
      end else if (clk_en) begin
         rdata <= regs[raddr];
      end
   end
endmodule

// ===== sim/byte_memory.sv
// behavioural byte-wide memory on the far side of the executor
module byte_memory (
   input wire logic core_clk,
   input wire logic [15:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // only 256 bytes: the upper address byte is ignored
   logic [7:0] mem [0:255];
   logic [7:0] rd;
   logic [7:0] held;
   logic [2:0] boot = 3'h0;
   // pointers start unknown, so such reads get a seeding stub
   assign rd = $isunknown(mem_addr) ? (boot[2] ? 8'hB2 : 8'hA2)
      : mem[mem_addr[7:0]];
   assign mem_rdata = mem_rd ? rd : ~held;
   always @(posedge core_clk) begin
      if (mem_rd)
         held <= rd;
      if (mem_rd && $isunknown(mem_addr))
         boot <= boot + 3'h1;
      if (mem_wr)
         mem[mem_addr[7:0]] <= mem_wdata;
   end
endmodule

// ===== sim/op_exec_chk.sv
// concurrent checks on the executor ports
module op_exec_chk (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata,
   input wire logic [7:0] acc,
   input wire logic [3:0] i_digit,
   input wire logic [3:0] n_digit,
   input wire logic [1:0] machine_state,
   input wire logic illegal_op
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking dc @(posedge core_clk);
   endclocking
   // a frozen clock enable stretches every count, so checks pause then
   default disable iff (!rstn || !clk_en);
   a_rd_width: assert property (
      $rose(mem_rd) |-> mem_rd[*4] ##1 !mem_rd)
      else $error("read strobe width wrong");
   a_wr_width: assert property (
      $rose(mem_wr) |-> mem_wr[*4] ##1 !mem_wr)
      else $error("write strobe width wrong");
   a_state_len: assert property (
      $changed(machine_state) |=>
      $stable(machine_state)[*7] ##1 $changed(machine_state))
      else $error("machine state length wrong");
   a_exec_order: assert property (
      $changed(machine_state) && machine_state == 2'b01
      |-> $past(machine_state) == 2'b00)
      else $error("execute without fetch");
   a_fetch_read: assert property (
      $changed(machine_state) && machine_state == 2'b00 |-> ##2 mem_rd)
      else $error("fetch read missing");
   a_digits_load: assert property (
      $fell(mem_rd) && machine_state == 2'b00
      |-> {i_digit, n_digit} == $past(mem_rdata))
      else $error("digits not loaded");
   a_acc_load: assert property (
      $fell(mem_rd) && machine_state != 2'b00 |-> acc == $past(mem_rdata))
      else $error("accumulator not loaded");
   a_store_data: assert property (
      mem_wr |-> mem_wdata == acc && $stable(acc))
      else $error("store data wrong");
   a_fetch_nowr: assert property (
      machine_state == 2'b00 |-> !mem_wr)
      else $error("write during fetch");
   a_illegal_quiet: assert property (
      machine_state == 2'b01 && {i_digit, n_digit} != 8'h68 |-> !illegal_op)
      else $error("illegal flag without illegal code");
endmodule
bind register_memory_op_exec op_exec_chk i_chk (.core_clk, .rstn, .clk_en,
   .mem_rd, .mem_wr, .mem_wdata, .mem_rdata, .acc, .i_digit, .n_digit,
   .machine_state, .illegal_op);

// ===== sim/tb_top.sv
// self-checking bench for the register and memory-reference executor
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [255:0] prog =
      256'hF8FFA3B313932383F840A3F800B3F87753F8114383607283F89E73F083031303;
   logic core_clk, rstn, clk_en, mem_rd, mem_wr, illegal_op;
   logic [3:0] p_sel, x_sel, i_digit, n_digit;
   logic [15:0] mem_addr;
   logic [7:0] mem_wdata, mem_rdata, acc;
   logic [1:0] machine_state;
   int fails = 0;
   int total_checks = 0;
   int cycles = 0;
   register_memory_op_exec i_dut (.core_clk, .rstn, .clk_en, .p_sel, .x_sel,
      .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata, .acc, .i_digit,
      .n_digit, .machine_state, .illegal_op);
   byte_memory i_mem (.core_clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata,
      .mem_rdata);
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   task automatic stop_test;
      if (fails == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // every instruction but the long group is one fetch and one execute state of 8 ticks
   task automatic step(input int n);
      repeat (16 * n) @(negedge core_clk);
   endtask
   task automatic run_wrap;
      step(1);
      chk(acc, 8'hFF);
      step(4);
      chk(acc, 8'h00);
      step(2);
      chk(acc, 8'hFF);
   endtask
   task automatic run_ptr_load;
      step(8);
      chk(acc, 8'h77);
      chk(i_mem.mem[8'h40], 8'h77);
      chk(mem_addr[7:0], 8'h40);
      step(1);
      chk(acc, 8'h41);
   endtask
   task automatic run_operand;
      step(2);
      chk(acc, 8'hC5);
      step(1);
      chk(acc, 8'h43);
      step(3);
      chk(acc, 8'hC5);
      step(1);
      chk(acc, 8'h42);
   endtask
   // a low enable must hold the next fetch, so the digits keep 83
   task automatic run_freeze;
      clk_en = 1'b0;
      repeat (8) @(negedge core_clk);
      chk({i_digit, n_digit}, 8'h83);
      clk_en = 1'b1;
   endtask
   task automatic run_load_sel;
      step(1);
      chk(acc, 8'hC5);
      step(2);
      chk(acc, 8'h9E);
      chk(i_mem.mem[8'h43], 8'h9E);
   endtask
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 1000) begin
         fails++;
         stop_test;
      end
   end
   initial begin
      rstn = 1'b0;
      clk_en = 1'b1;
      p_sel = 4'h1;
      x_sel = 4'h3;
      for (int k = 0; k < 256; k++)
         i_mem.mem[k] = 8'h00;
      for (int k = 0; k < 32; k++)
         i_mem.mem[k] = prog[255 - 8 * k -: 8];
      i_mem.mem[8'h42] = 8'hC5;
      repeat (4) @(negedge core_clk);
      rstn = 1'b1;
      // two stub fetches clear R2 from the zero accumulator
      step(2);
      p_sel = 4'h2;
      run_wrap;
      run_ptr_load;
      run_operand;
      run_freeze;
      run_load_sel;
      stop_test;
   end
endmodule
